// >>> hdl/adc_chain_cfg.svh
// Constants shared by both ends of the daisy-chain converter readout.
// Assumes the core clocks of both ends run at CLK_PERIOD_NS.
`ifndef ADC_CHAIN_CFG_SVH
`define ADC_CHAIN_CFG_SVH

// Core clock period and conversion time, in ns.
`define CLK_PERIOD_NS 40
`define CONV_TIME_NS  1400
// Least conversion time rounds up to whole core cycles.
`define CONV_CYCLES   ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Result word, chain length and counter width.
`define WORD_BITS     16
`define CHAIN_LEN     2
`define CNT_W         8

// Host serial clock half period and wait after conversion, in cycles.
`define SCLK_HALF     4
`define READ_GUARD    8

// Level of the busy-indicator bit and idle levels.
`define BUSY_BIT      1'b0
`define OE_N_RESET    1'b1

`endif

// >>> hdl/adc_chain_pkg.sv
// Types shared by both ends of the daisy-chain converter readout.
// Assumes adc_chain_cfg.svh is on the include path.
`include "adc_chain_cfg.svh"

package adc_chain_pkg;

    typedef logic [`WORD_BITS-1:0] word_t;
    typedef logic [`CNT_W-1:0]     cnt_t;

    typedef enum logic [2:0] {
        DEV_IDLE = 3'b001,
        DEV_CONV = 3'b010,
        DEV_READ = 3'b100
    } dev_state_t;

    typedef enum logic [4:0] {
        H_IDLE  = 5'b00001,
        H_SETUP = 5'b00010,
        H_CONV  = 5'b00100,
        H_SHIFT = 5'b01000,
        H_END   = 5'b10000
    } host_state_t;

endpackage : adc_chain_pkg

// >>> hdl/adc_chain_if.sv
// Link between a chain of converters and the digital host.
// Assumes the bench drives serial_chain_in (tied low or to convert_start).
`timescale 1ns/1ps

interface adc_chain_if;
    logic convert_start;
    logic sclk;
    logic serial_chain_in;
    logic serial_chain_out;
    logic serial_chain_out_oe_n;
    logic chain_line;

    // An undriven chain output reads low, as with a weak pull-down.
    assign chain_line = serial_chain_out & ~serial_chain_out_oe_n;

    modport dev (
        input  convert_start,
        input  sclk,
        input  serial_chain_in,
        output serial_chain_out,
        output serial_chain_out_oe_n
    );

    modport host (
        output convert_start,
        output sclk,
        input  chain_line
    );
endinterface : adc_chain_if

// >>> hdl/adc_chain_dev.sv
// One converter of a daisy chain: conversion on the core clock, result
// readout on the serial clock from the link.
// Assumes the host keeps the link protocol and the bench wires the chain.
//
// Contract
// - Chain input low at start selects chain
// - Output low while input and start low
// - Start edge samples input, begins conversion
// - Serial clock low at start: no busy
// - Serial clock high at start: busy bit
// - Host holds start high through readout
// - Conversion finishes whatever the serial clock
// - No busy: MSB first, shift on fall
// - Capture chain input on every falling edge but the first in busy mode
// - No busy: first device low after 16th fall
// - Predecessor data follows own word directly
// - No busy: host gives 16 clocks each
// - Busy: busy bit, then MSB on fall
// - Busy: first device high after 17th
// - Busy: host gives 16 each plus one
// - Input rising with start still selects chain
// - No busy: first chain input tied low
// - Power down after conversion, up at start
// - Output code is two's complement
// - Host reads after conversion, clock stopped
`timescale 1ns/1ps
`include "adc_chain_cfg.svh"

module adc_chain_dev (
    // Core clock and reset
    input  wire logic                 CLK_I,
    input  wire logic                 ARST_N_I,
    // Link to the host and the neighbours
    adc_chain_if.dev                  LNK,
    // Quantiser code, zero at negative full scale
    input  wire adc_chain_pkg::word_t ANALOG_CODE_I,
    // Status
    output logic                      POWERED_UP_O,
    output logic                      RESULT_VALID_O
);

    import adc_chain_pkg::*;

    ////////////////////////////////////////////////////////////////////

    // Maps the offset quantiser code to the output coding.
    function automatic word_t to_out_code(input word_t code);
        to_out_code = {~code[`WORD_BITS-1], code[`WORD_BITS-2:0]};
    endfunction : to_out_code

    ////////////////////////////////////////////////////////////////////

    logic       cvs_m_r;
    logic       cvs_s_r;
    logic       cvs_q_r;
    logic       din_m_r;
    logic       din_s_r;
    logic       din_q_r;
    logic       clk_m_r;
    logic       clk_s_r;
    logic       clk_q_r;
    logic       start_rise;
    logic       chain_sel;
    logic       both_low;
    dev_state_t state_r;
    cnt_t       timer_r;
    word_t      sample_r;
    word_t      word_r;
    logic       busy_r;
    logic       done_r;
    logic       head_r;
    logic       oe_n_r;
    logic       pwr_r;
    logic       link_rst_n;
    logic       act_r;
    word_t      sreg_r;
    word_t      out_code;

    ////////////////////////////////////////////////////////////////////

    // Link pins reach the core clock through two flip-flops each; the
    // third stage holds the level seen just before the current one.
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cvs_m_r <= 1'b0;
            cvs_s_r <= 1'b0;
            cvs_q_r <= 1'b0;
            din_m_r <= 1'b0;
            din_s_r <= 1'b0;
            din_q_r <= 1'b0;
            clk_m_r <= 1'b0;
            clk_s_r <= 1'b0;
            clk_q_r <= 1'b0;
        end else begin
            cvs_m_r <= LNK.convert_start;
            cvs_s_r <= cvs_m_r;
            cvs_q_r <= cvs_s_r;
            din_m_r <= LNK.serial_chain_in;
            din_s_r <= din_m_r;
            din_q_r <= din_s_r;
            clk_m_r <= LNK.sclk;
            clk_s_r <= clk_m_r;
            clk_q_r <= clk_s_r;
        end
    end

    assign start_rise = cvs_s_r & ~cvs_q_r;
    // The chain input is judged one sample before the start edge, so an
    // input that rises together with the start still selects the chain.
    assign chain_sel  = ~din_q_r;
    assign both_low   = ~cvs_s_r & ~din_s_r;
    assign out_code   = to_out_code(sample_r);

    ////////////////////////////////////////////////////////////////////

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_r <= DEV_IDLE;
        end else begin
            case (state_r)
                DEV_IDLE: begin
                    if (start_rise && chain_sel) begin
                        state_r <= DEV_CONV;
                    end
                end
                DEV_CONV: begin
                    // The start level and serial clock are not looked at.
                    if (timer_r == '0) begin
                        state_r <= DEV_READ;
                    end
                end
                DEV_READ: begin
                    if (!cvs_s_r) begin
                        state_r <= DEV_IDLE;
                    end
                end
                default: begin
                    state_r <= DEV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            timer_r <= '0;
        end else if (state_r == DEV_IDLE && start_rise && chain_sel) begin
            timer_r <= cnt_t'(`CONV_CYCLES - 1);
        end else if (state_r == DEV_CONV && timer_r != '0) begin
            timer_r <= timer_r - cnt_t'(1);
        end
    end

    // Sample, result and readout mode.
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sample_r <= '0;
            word_r   <= '0;
            busy_r   <= 1'b0;
        end else if (state_r == DEV_IDLE && start_rise && chain_sel) begin
            sample_r <= ANALOG_CODE_I;
            busy_r   <= clk_q_r;
        end else if (state_r == DEV_CONV && timer_r == '0) begin
            word_r   <= to_out_code(sample_r);
        end
    end

    // The result stays readable until the start line falls.
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            done_r <= 1'b0;
        end else if (state_r == DEV_CONV && timer_r == '0) begin
            done_r <= 1'b1;
        end else if (!cvs_s_r || start_rise) begin
            done_r <= 1'b0;
        end
    end

    // Level shown on the chain output before the first falling edge.
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            head_r <= 1'b0;
        end else if (both_low) begin
            head_r <= 1'b0;
        end else if (state_r == DEV_CONV && timer_r == '0) begin
            if (busy_r) begin
                head_r <= `BUSY_BIT;
            end else begin
                head_r <= out_code[`WORD_BITS-1];
            end
        end else if (start_rise) begin
            head_r <= 1'b0;
        end
    end

    // Only chain operation is served; any other start releases the line.
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            oe_n_r <= `OE_N_RESET;
        end else if (both_low) begin
            oe_n_r <= 1'b0;
        end else if (start_rise) begin
            oe_n_r <= ~chain_sel;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pwr_r <= 1'b0;
        end else if (state_r == DEV_IDLE && start_rise && chain_sel) begin
            pwr_r <= 1'b1;
        end else if (state_r == DEV_CONV && timer_r == '0) begin
            pwr_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////

    // Serial clock domain. The mode is written at the start edge, the result
    // and done flag once at conversion end; all then hold until the start line falls,
    // so they are read here as settled levels. A falling edge that lands
    // during conversion is ignored because done is still low.
    assign link_rst_n = ARST_N_I & LNK.convert_start;

    always_ff @(negedge LNK.sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            act_r  <= 1'b0;
            sreg_r <= '0;
        end else if (done_r) begin
            act_r <= 1'b1;
            if (!act_r && busy_r) begin
                // The busy bit gives way to the MSB; the neighbour's
                // busy bit is not captured.
                sreg_r <= word_r;
            end else if (!act_r) begin
                sreg_r <= {word_r[`WORD_BITS-2:0],
                           LNK.serial_chain_in};
            end else begin
                // A grounded input gives low after all own bits; an
                // input tied to the start line gives high.
                sreg_r <= {sreg_r[`WORD_BITS-2:0],
                           LNK.serial_chain_in};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////

    assign LNK.serial_chain_out      = act_r ? sreg_r[`WORD_BITS-1]
                                             : head_r;
    assign LNK.serial_chain_out_oe_n = oe_n_r;
    assign POWERED_UP_O              = pwr_r;
    assign RESULT_VALID_O            = done_r;

endmodule : adc_chain_dev

// >>> hdl/adc_chain_host.sv
// Digital host of a converter chain: starts a conversion, makes the
// serial clock by dividing its own clock and collects every word.
// Assumes CHAIN_LEN converters and the chain input wired as the mode asks.
`timescale 1ns/1ps
`include "adc_chain_cfg.svh"

module adc_chain_host (
    // Core clock and reset
    input  wire logic                 CLK_I,
    input  wire logic                 ARST_N_I,
    // Link to the chain
    adc_chain_if.host                 LNK,
    // Request
    input  wire logic                 START_I,
    input  wire logic                 BUSY_MODE_I,
    output logic                      READY_O,
    // Collected words, last device first
    output adc_chain_pkg::word_t      DATA_O,
    output logic                      DATA_VALID_O,
    output logic                      DONE_O
);

    import adc_chain_pkg::*;

    ////////////////////////////////////////////////////////////////////

    logic        ln_m_r;
    logic        ln_s_r;
    host_state_t state_r;
    cnt_t        timer_r;
    cnt_t        falls_r;
    cnt_t        total;
    logic        mode_r;
    logic        cvs_r;
    logic        sclk_r;
    logic [3:0]  bit_r;
    word_t       shift_r;
    word_t       data_r;
    logic        valid_r;
    logic        done_r;
    logic        ready_r;
    logic        tick;
    logic        fall_now;

    // Sixteen falls per device, one more when a busy bit leads.
    assign total    = cnt_t'(`WORD_BITS * `CHAIN_LEN)
                    + cnt_t'(mode_r);
    assign tick     = (timer_r == '0);
    assign fall_now = (state_r == H_SHIFT) && tick && sclk_r;

    ////////////////////////////////////////////////////////////////////

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ln_m_r <= 1'b0;
            ln_s_r <= 1'b0;
        end else begin
            ln_m_r <= LNK.chain_line;
            ln_s_r <= ln_m_r;
        end
    end

    ////////////////////////////////////////////////////////////////////

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_r <= H_IDLE;
        end else begin
            case (state_r)
                H_IDLE: begin
                    if (START_I) begin
                        state_r <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    state_r <= H_CONV;
                end
                H_CONV: begin
                    if (tick) begin
                        state_r <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (fall_now && falls_r == total - cnt_t'(1)) begin
                        state_r <= H_END;
                    end
                end
                H_END: begin
                    if (tick) begin
                        state_r <= H_IDLE;
                    end
                end
                default: begin
                    state_r <= H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            timer_r <= '0;
        end else if (state_r == H_SETUP) begin
            // Reading waits out the whole conversion.
            timer_r <= cnt_t'(`CONV_CYCLES + `READ_GUARD - 1);
        end else if (state_r != H_IDLE && tick) begin
            timer_r <= cnt_t'(`SCLK_HALF - 1);
        end else if (!tick) begin
            timer_r <= timer_r - cnt_t'(1);
        end
    end

    // The serial clock level is set before the start edge and held
    // still through the conversion.
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            mode_r <= 1'b0;
            sclk_r <= 1'b0;
        end else if (state_r == H_IDLE && START_I) begin
            mode_r <= BUSY_MODE_I;
            sclk_r <= BUSY_MODE_I;
        end else if (state_r == H_SHIFT && tick) begin
            sclk_r <= ~sclk_r;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cvs_r <= 1'b0;
        end else if (state_r == H_SETUP) begin
            cvs_r <= 1'b1;
        end else if (state_r == H_END && tick) begin
            cvs_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            falls_r <= '0;
        end else if (state_r == H_SETUP) begin
            falls_r <= '0;
        end else if (fall_now) begin
            falls_r <= falls_r + cnt_t'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////

    // The line is sampled just before each fall; a leading busy bit is
    // skipped.
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            bit_r   <= '0;
            shift_r <= '0;
            data_r  <= '0;
            valid_r <= 1'b0;
        end else begin
            valid_r <= 1'b0;
            if (state_r == H_SETUP) begin
                bit_r <= '0;
            end else if (fall_now && falls_r >= cnt_t'(mode_r)) begin
                shift_r <= {shift_r[`WORD_BITS-2:0], ln_s_r};
                bit_r   <= bit_r + 4'h1;
                if (bit_r == 4'hf) begin
                    data_r  <= {shift_r[`WORD_BITS-2:0], ln_s_r};
                    valid_r <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            done_r  <= 1'b0;
            ready_r <= 1'b1;
        end else begin
            done_r  <= (state_r == H_END) && tick;
            ready_r <= (state_r == H_IDLE && !START_I) ||
                       (state_r == H_END && tick);
        end
    end

    ////////////////////////////////////////////////////////////////////

    assign LNK.convert_start = cvs_r;
    assign LNK.sclk          = sclk_r;
    assign READY_O           = ready_r;
    assign DATA_O            = data_r;
    assign DATA_VALID_O      = valid_r;
    assign DONE_O            = done_r;

endmodule : adc_chain_host

// >>> sim/adc_chain_props.sv
// Checker for the link of the first converter in the chain.
// Assumes the host is the only source of convert_start and sclk.
`timescale 1ns/1ps
`include "adc_chain_cfg.svh"

module adc_chain_props (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    // Link signals
    input wire logic convert_start,
    input wire logic sclk,
    input wire logic serial_chain_in,
    input wire logic serial_chain_out,
    input wire logic serial_chain_out_oe_n,
    input wire logic chain_line
);
    localparam int CONV_END = `CONV_CYCLES + 3;
    localparam int N_FALLS  = `WORD_BITS * `CHAIN_LEN;

    logic       cs_q_r;
    logic       sclk_q_r;
    logic       busy_r;
    logic       started_r;
    logic [7:0] falls_r;
    logic [7:0] cyc_r;
    logic       cs_rise;
    logic       cs_fall;

    assign cs_rise = convert_start && !cs_q_r;
    assign cs_fall = !convert_start && cs_q_r;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cs_q_r   <= 1'b0;
            sclk_q_r <= 1'b0;
        end else begin
            cs_q_r   <= convert_start;
            sclk_q_r <= sclk;
        end
    end

    // The serial clock level at the start edge selects the busy variant.
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            busy_r    <= 1'b0;
            started_r <= 1'b0;
        end else if (cs_rise) begin
            busy_r    <= sclk;
            started_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            falls_r <= 8'h00;
            cyc_r   <= 8'h00;
        end else if (!convert_start) begin
            falls_r <= 8'h00;
            cyc_r   <= 8'h00;
        end else begin
            if (sclk_q_r && !sclk) begin
                falls_r <= falls_r + 8'h01;
            end
            if (cyc_r != 8'hff) begin
                cyc_r <= cyc_r + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_chain_sel;
        cs_rise && !$past(serial_chain_in) |-> ##3 !serial_chain_out_oe_n [*8];
    endproperty
    a_chain_sel: assert property (p_chain_sel)
        else $error("chain output released after start");

    property p_low_drive;
        (!convert_start && !serial_chain_in) [*6]
            |-> !serial_chain_out_oe_n && !serial_chain_out;
    endproperty
    a_low_drive: assert property (p_low_drive)
        else $error("chain output not driven low");

    property p_idle;
        !started_r |-> !chain_line;
    endproperty
    a_idle: assert property (p_idle)
        else $error("chain line active before first start");

    property p_busy_bit;
        busy_r && convert_start && cyc_r == 8'd40
            |-> !serial_chain_out_oe_n && serial_chain_out == `BUSY_BIT;
    endproperty
    a_busy_bit: assert property (p_busy_bit)
        else $error("busy bit missing at conversion end");

    property p_first_low;
        !busy_r && convert_start && falls_r >= 8'd16 |-> !chain_line;
    endproperty
    a_first_low: assert property (p_first_low)
        else $error("first device not low after its word");

    property p_first_high;
        busy_r && convert_start && falls_r >= 8'd17 |-> chain_line;
    endproperty
    a_first_high: assert property (p_first_high)
        else $error("first device not high after its word");

    property p_count;
        cs_fall |-> falls_r == N_FALLS + busy_r;
    endproperty
    a_count: assert property (p_count)
        else $error("wrong number of serial clock falls");

    property p_no_clk;
        convert_start && cyc_r < CONV_END |-> $stable(sclk);
    endproperty
    a_no_clk: assert property (p_no_clk)
        else $error("serial clock moved during conversion");

    c_busy:   cover property (cs_rise && sclk);
    c_nobusy: cover property (cs_rise && !sclk);
    c_end:    cover property (cs_fall);

endmodule : adc_chain_props

// >>> sim/adc_daisy_chain_serial_readout_tb_top.sv
// Bench for a two-converter chain read by its host in both variants.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps

module adc_daisy_chain_serial_readout_tb_top;
    import adc_chain_pkg::*;

    logic  clk;
    logic  arst_n;
    logic  start;
    logic  busy_mode;
    word_t code_a;
    word_t code_b;
    word_t data;
    logic  data_valid;
    logic  done;
    logic  ready;
    logic  pu_a;
    logic  pu_b;
    logic  rv_a;
    logic  rv_b;
    int    err_count;
    int    checked;
    int    cycles;
    word_t tab_a [3] = '{16'hffff, 16'h8000, 16'h1234};
    word_t tab_b [3] = '{16'h0000, 16'h7fff, 16'hedcb};

    adc_chain_if if_a ();
    adc_chain_if if_b ();

    // Device a heads the chain; device b feeds the host.
    assign if_a.convert_start   = if_b.convert_start;
    assign if_a.sclk            = if_b.sclk;
    assign if_a.serial_chain_in = busy_mode ? if_b.convert_start
                                            : 1'b0;
    assign if_b.serial_chain_in = if_a.chain_line;

    adc_chain_dev i_adc_chain_dev_a (
        .CLK_I(clk), .ARST_N_I(arst_n), .LNK(if_a), .ANALOG_CODE_I(code_a),
        .POWERED_UP_O(pu_a), .RESULT_VALID_O(rv_a));

    adc_chain_dev i_adc_chain_dev_b (
        .CLK_I(clk), .ARST_N_I(arst_n), .LNK(if_b), .ANALOG_CODE_I(code_b),
        .POWERED_UP_O(pu_b), .RESULT_VALID_O(rv_b));

    adc_chain_host i_adc_chain_host (
        .CLK_I(clk), .ARST_N_I(arst_n), .LNK(if_b), .START_I(start),
        .BUSY_MODE_I(busy_mode), .READY_O(ready), .DATA_O(data),
        .DATA_VALID_O(data_valid), .DONE_O(done));

    adc_chain_props i_adc_chain_props (
        .CLK_I(clk), .ARST_N_I(arst_n),
        .convert_start(if_a.convert_start), .sclk(if_a.sclk),
        .serial_chain_in(if_a.serial_chain_in),
        .serial_chain_out(if_a.serial_chain_out),
        .serial_chain_out_oe_n(if_a.serial_chain_out_oe_n),
        .chain_line(if_a.chain_line));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // One readout; a second request during it must be ignored.
    task automatic xfer(input logic bm, input word_t c_a, input word_t c_b);
        word_t got[$];
        int    n;
        n = 0;
        while (ready !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        busy_mode <= bm;
        code_a    <= c_a;
        code_b    <= c_b;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
            if (n == 20) begin
                check(16'({pu_a, pu_b, rv_a, rv_b}), 16'h000c);
            end
            if (data_valid === 1'b1) begin
                got.push_back(data);
                start <= (got.size() == 1);
                if (got.size() == 1) begin
                    check(16'({pu_a, pu_b, rv_a, rv_b}), 16'h0003);
                end
            end else begin
                start <= 1'b0;
            end
        end
        check(16'(got.size()), 16'h0002);
        check(got[0], c_b ^ 16'h8000);
        check(got[1], c_a ^ 16'h8000);
    endtask : xfer

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        arst_n    = 1'b0;
        start     = 1'b0;
        busy_mode = 1'b0;
        code_a    = '0;
        code_b    = '0;
        err_count = 0;
        checked   = 0;
        cycles    = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check(16'({if_a.chain_line, if_b.chain_line, ready}), 16'h0001);
        check(16'({pu_a, rv_a, pu_b, rv_b}), 16'h0000);
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 3; k++) begin
                xfer(m[0], tab_a[k], tab_b[k]);
            end
        end
        test_done();
    end

endmodule : adc_daisy_chain_serial_readout_tb_top
